// >>> inc/msp_pkg.sv
// msp_pkg: constants and types for the spi master/slave port
// assumes one user of the plain register port, byte-wide data
package msp_pkg;
   // register index on the plain port
   localparam logic [2:0] A_CTL1 = 3'h0;
   localparam logic [2:0] A_STAT = 3'h1;
   localparam logic [2:0] A_CTL3 = 3'h2;
   localparam logic [2:0] A_DATA = 3'h3;
   localparam logic [2:0] A_RELOAD = 3'h4;
   localparam logic [2:0] A_IRQ = 3'h5;
   // control_one_reg fields
   localparam int B_WRITE_COLLISION_FLAG = 7;
   localparam int B_EN = 5;
   localparam int B_POL = 4;
   // port_status_reg fields
   localparam int B_SMP = 7;
   localparam int B_CKE = 6;
   localparam int B_BF = 0;
   // control_three_reg and irq register fields
   localparam int B_BUFFER_OVERWRITE_EN = 4;
   localparam int B_IRQ = 0;
   // mode field codes
   localparam logic [3:0] M_DIV4 = 4'h0;
   localparam logic [3:0] M_DIV16 = 4'h1;
   localparam logic [3:0] M_DIV64 = 4'h2;
   localparam logic [3:0] M_TMR2 = 4'h3;
   localparam logic [3:0] M_SLV_SS = 4'h4;
   localparam logic [3:0] M_SLV = 4'h5;
   localparam logic [3:0] M_RELOAD = 4'ha;
   // half of one serial clock period, in mclk cycles
   localparam logic [9:0] HALF_DIV4 = 10'h002;
   localparam logic [9:0] HALF_DIV16 = 10'h008;
   localparam logic [9:0] HALF_DIV64 = 10'h020;
   // master walks 16 clock edges, then one closing half period
   localparam logic [4:0] EDGE_LAST = 5'h10;
   localparam logic [4:0] BIT_LAST = 5'h07;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] RST_MODE = 4'h0;
   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} msp_state_e;
endpackage : msp_pkg

// >>> rtl/msp_sync.sv
// msp_sync: two-flop synchroniser for a group of pin inputs
// assumes inputs are asynchronous to clk_i; q_o is the second stage
`timescale 1ns/1ps
`default_nettype none
module msp_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= RST_VAL;
         q_o <= RST_VAL;
      end else begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule : msp_sync
`default_nettype wire

// >>> rtl/msp_top.sv
// msp_top: spi port working as master or slave, byte-wide register port
// assumes sck, sdi and select pins are asynchronous; sleep and timer tick
// come from logic on mclk_i
//
// Behaviour
// RULE1 - software enables the port; reconfigures with enable cleared
// RULE2 - msb first; full byte goes to buffer, sets buffer-full and irq flag
// RULE3 - buffer write while busy is dropped, sets collision flag
// RULE4 - reading the data buffer clears buffer-full
// RULE5 - idle buffer write loads buffer and shift register together; code drops it while the collision flag is set
// RULE6 - master starts on buffer write and drives the clock pin
// RULE7 - slave shifts on external clock edges, flag on last bit
// RULE8 - master rate: osc/4, /16, /64, timer/2 or osc/(4*(reload+1))
// RULE9 - polarity bit gives clock idle level, slave reference too
// RULE10 - edge bit set: data valid before first clock edge
// RULE11 - master sample phase: middle or end of output time
// RULE12 - software keeps sample phase clear in slave mode
// RULE13 - clock pin idles at polarity level before slave enable
// RULE14 - receive-only master keeps sampling with normal flags
// RULE15 - overwrite enable accepts writes and updates with unread byte
// RULE16 - slave shifts out the byte received in the previous group
// RULE17 - mode code 0100 selects select-pin synchronised slave
// RULE18 - select low: transfer enabled, data output driven
// RULE19 - select high: data output released at once, port reset; code does both only after the two-flop synchroniser, output three cycles late
// RULE20 - port reset forces the bit counter to zero
// RULE21 - software uses select control for slave with edge bit set
// RULE22 - master freezes during sleep, resumes afterwards
// RULE23 - slave runs from external clock in sleep, flag wakes device
// RULE24 - mode codes decode to the master rates and the two slaves
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module msp_top (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic [2:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic sleep_i,
   input wire logic tmr2_tick_i,
   input wire logic sck_i,
   input wire logic sdi_i,
   input wire logic ss_n_i,
   output logic sck_o,
   output logic sck_oe_o,
   output logic sdo_o,
   output logic sdo_oe_o,
   output logic port_irq_flag_o
);
   logic sck_s, sdi_s, ss_n_s, sck_p_q;
   logic en_q, pol_q, write_collision_flag_q, smp_q, cke_q, buffer_overwrite_en_q, bf_q;
   logic [3:0] mode_q;
   logic [7:0] buf_q, reload_q, sr_q;
   logic [9:0] div_q, half_lim;
   logic [4:0] cnt_q;
   msp_pkg::msp_state_e st_q;
   logic master, slave, ss_mode, port_rst, slave_en, busy;
   logic buf_wr, load_ok, collide, half_tick, done;
   logic lead, trail, m_samp, m_out, s_samp, s_out, samp, outp, m_s1_q, m_s2_q;

   // RULE24 master codes
   function automatic logic is_master(input logic [3:0] m);
      is_master = (m == msp_pkg::M_DIV4) || (m == msp_pkg::M_DIV16) ||
                  (m == msp_pkg::M_DIV64) || (m == msp_pkg::M_TMR2) ||
                  (m == msp_pkg::M_RELOAD);
   endfunction : is_master

   // RULE8 half period
   function automatic logic [9:0] half_of(input logic [3:0] m,
                                          input logic [7:0] r);
      case (m)
         msp_pkg::M_DIV16: half_of = msp_pkg::HALF_DIV16;
         msp_pkg::M_DIV64: half_of = msp_pkg::HALF_DIV64;
         msp_pkg::M_RELOAD: half_of = {1'b0, r, 1'b0} + msp_pkg::HALF_DIV4;
         default: half_of = msp_pkg::HALF_DIV4;
      endcase
   endfunction : half_of

   // pins cross into mclk; select idles high (deselected)
   msp_sync #(.W(3), .RST_VAL(3'h1)) u_sync (
      .clk_i(mclk_i),
      .rst_i(sys_rst_i),
      .d_i({sck_i, sdi_i, ss_n_i}),
      .q_o({sck_s, sdi_s, ss_n_s})
   );

   // sdi lags two flops, so master samples wait two cycles for it
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         sck_p_q <= 1'b0;
         {m_s2_q, m_s1_q} <= 2'h0;
      end else begin
         sck_p_q <= sck_s;
         {m_s2_q, m_s1_q} <= {m_s1_q, m_samp};
      end
   end

   assign master = is_master(mode_q);
   // RULE24 slave codes
   assign slave = (mode_q == msp_pkg::M_SLV) || (mode_q == msp_pkg::M_SLV_SS);
   // RULE17 select control
   assign ss_mode = (mode_q == msp_pkg::M_SLV_SS);
   // RULE19 select high resets
   assign port_rst = !en_q || (ss_mode && ss_n_s);
   // RULE18 select low enables
   assign slave_en = slave && !port_rst;
   assign busy = (st_q != msp_pkg::ST_IDLE);
   assign done = (st_q == msp_pkg::ST_DONE);

   assign buf_wr = wr_i && (addr_i == msp_pkg::A_DATA);
   // RULE15 overwrite allowed
   assign load_ok = buf_wr && en_q && !busy && !write_collision_flag_q && (!bf_q || buffer_overwrite_en_q);
   // RULE3 collision detect
   assign collide = buf_wr && en_q && busy;

   // RULE22 sleep freezes master
   assign half_lim = half_of(mode_q, reload_q);
   assign half_tick = (st_q == msp_pkg::ST_RUN) && master && !sleep_i &&
                      ((mode_q == msp_pkg::M_TMR2) ? tmr2_tick_i
                                                   : (div_q == half_lim - 10'h001));

   // RULE10 output edge choice
   assign m_out = half_tick && (cnt_q[0] == cke_q) && (cnt_q < msp_pkg::EDGE_LAST);
   // RULE11 sample phase
   assign m_samp = half_tick && (smp_q ? ((cnt_q[0] == cke_q) && (cnt_q != 5'h00))
                                       : ((cnt_q[0] != cke_q) &&
                                          (cnt_q < msp_pkg::EDGE_LAST)));

   // RULE9 edges against idle
   assign lead = (sck_s != sck_p_q) && (sck_s != pol_q);
   assign trail = (sck_s != sck_p_q) && (sck_s == pol_q);
   // RULE7 external clock shifts
   assign s_samp = slave_en && (cke_q ? lead : trail);
   assign s_out = slave_en && (cke_q ? trail : lead);
   assign samp = m_s2_q || s_samp;
   assign outp = m_out || s_out;

   // sequence control
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i || port_rst) begin
         st_q <= msp_pkg::ST_IDLE;
      end else begin
         case (st_q)
            msp_pkg::ST_IDLE: begin
               // RULE6 start on write
               if (load_ok && master) begin
                  st_q <= msp_pkg::ST_RUN;
               end else if (slave_en && (lead || trail)) begin
                  st_q <= msp_pkg::ST_RUN;
               end
            end
            msp_pkg::ST_RUN: begin
               if (half_tick && (cnt_q == msp_pkg::EDGE_LAST)) begin
                  st_q <= msp_pkg::ST_DONE;
               end else if (s_samp && (cnt_q == msp_pkg::BIT_LAST)) begin
                  st_q <= msp_pkg::ST_DONE;
               end
            end
            msp_pkg::ST_DONE: begin
               st_q <= msp_pkg::ST_IDLE;
            end
            default: begin
               st_q <= msp_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // rate divider; restarts each half period
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i || port_rst || (st_q != msp_pkg::ST_RUN) || half_tick) begin
         div_q <= 10'h000;
      end else if (!sleep_i) begin
         div_q <= div_q + 10'h001;
      end
   end

   // edge count for master, bit count for slave
   always_ff @(posedge mclk_i) begin
      // RULE20 counter cleared
      if (sys_rst_i || port_rst || done) begin
         cnt_q <= 5'h00;
      end else if (half_tick || s_samp) begin
         cnt_q <= cnt_q + 5'h01;
      end
   end

   // shift register and data output
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         sr_q <= msp_pkg::RST_BYTE;
         sdo_o <= 1'b0;
      end else if (load_ok) begin
         // RULE5 load both
         sr_q <= wdata_i;
         sdo_o <= wdata_i[7];
      end else begin
         // RULE2 msb first
         if (samp) begin
            sr_q <= {sr_q[6:0], sdi_s};
         end
         // RULE16 received byte recirculates
         if (outp) begin
            sdo_o <= samp ? sr_q[6] : sr_q[7];
         end
      end
   end

   // serial clock out, idles at polarity level
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         sck_o <= 1'b0;
      end else if (!master || (st_q != msp_pkg::ST_RUN)) begin
         // RULE9 idle level
         sck_o <= pol_q;
      end else if (half_tick && (cnt_q < msp_pkg::EDGE_LAST)) begin
         sck_o <= !sck_o;
      end
   end

   // pin drive enables
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         sck_oe_o <= 1'b0;
         sdo_oe_o <= 1'b0;
      end else begin
         // RULE6 clock driven
         sck_oe_o <= en_q && master;
         // RULE19 release on select
         sdo_oe_o <= en_q && (master || (slave && !(ss_mode && ss_n_s)));
      end
   end

   // control registers; change them only with the port disabled
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         en_q <= 1'b0;
         pol_q <= 1'b0;
         mode_q <= msp_pkg::RST_MODE;
         smp_q <= 1'b0;
         cke_q <= 1'b0;
         buffer_overwrite_en_q <= 1'b0;
         reload_q <= msp_pkg::RST_BYTE;
      end else if (wr_i) begin
         case (addr_i)
            msp_pkg::A_CTL1: begin
               // RULE1 enable bit
               en_q <= wdata_i[msp_pkg::B_EN];
               pol_q <= wdata_i[msp_pkg::B_POL];
               mode_q <= wdata_i[3:0];
            end
            msp_pkg::A_STAT: begin
               smp_q <= wdata_i[msp_pkg::B_SMP];
               cke_q <= wdata_i[msp_pkg::B_CKE];
            end
            msp_pkg::A_CTL3: begin
               buffer_overwrite_en_q <= wdata_i[msp_pkg::B_BUFFER_OVERWRITE_EN];
            end
            msp_pkg::A_RELOAD: begin
               reload_q <= wdata_i;
            end
            default: begin
            end
         endcase
      end
   end

   // collision flag: hardware set beats software clear
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         write_collision_flag_q <= 1'b0;
      end else if (collide) begin
         // RULE3 flag set
         write_collision_flag_q <= 1'b1;
      end else if (wr_i && (addr_i == msp_pkg::A_CTL1)) begin
         write_collision_flag_q <= write_collision_flag_q && wdata_i[msp_pkg::B_WRITE_COLLISION_FLAG];
      end
   end

   // receive buffer and buffer-full flag
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         buf_q <= msp_pkg::RST_BYTE;
         bf_q <= 1'b0;
      end else if (load_ok) begin
         buf_q <= wdata_i;
      end else if (done) begin
         // RULE14 byte stored if buffer empty or overwrite enabled
         if (!bf_q || buffer_overwrite_en_q) begin
            buf_q <= sr_q;
         end
         // RULE2 buffer full
         bf_q <= 1'b1;
      end else if (rd_i && (addr_i == msp_pkg::A_DATA)) begin
         // RULE4 read clears
         bf_q <= 1'b0;
      end
   end

   // completion flag; runs without sleep gating so it can wake the device
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         port_irq_flag_o <= 1'b0;
      end else if (done) begin
         // RULE23 byte sets flag
         port_irq_flag_o <= 1'b1;
      end else if (wr_i && (addr_i == msp_pkg::A_IRQ)) begin
         port_irq_flag_o <= port_irq_flag_o && wdata_i[msp_pkg::B_IRQ];
      end
   end

   // read port: data stand for one cycle after the strobe
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i || !rd_i) begin
         rdata_o <= 8'h00;
      end else begin
         case (addr_i)
            msp_pkg::A_CTL1: rdata_o <= {write_collision_flag_q, 1'b0, en_q, pol_q, mode_q};
            msp_pkg::A_STAT: rdata_o <= {smp_q, cke_q, 5'h00, bf_q};
            msp_pkg::A_CTL3: rdata_o <= {3'h0, buffer_overwrite_en_q, 4'h0};
            msp_pkg::A_DATA: rdata_o <= buf_q;
            msp_pkg::A_RELOAD: rdata_o <= reload_q;
            msp_pkg::A_IRQ: rdata_o <= {7'h00, port_irq_flag_o};
            default: rdata_o <= 8'h00;
         endcase
      end
   end
endmodule : msp_top
`default_nettype wire

// >>> verif/msp_top_assertions.sv
// checker for the msp_top port behaviour
// bound to msp_top, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module msp_top_assertions (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic [2:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic sleep_i,
   input wire logic ss_n_i,
   input wire logic sck_o,
   input wire logic sck_oe_o,
   input wire logic sdo_oe_o,
   input wire logic port_irq_flag_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (sys_rst_i);
   logic [4:0] edges_q;
   // the enable edge is no clock edge, hence the past term
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i || !sck_oe_o || $rose(port_irq_flag_o)) begin
         edges_q <= 5'h00;
      end else if ($past(sck_oe_o) && sck_o != $past(sck_o)) begin
         edges_q <= edges_q + 5'h01;
      end
   end
   sequence s_data_rd;
      rd_i && addr_i == msp_pkg::A_DATA;
   endsequence
   sequence s_stat_rd;
      rd_i && addr_i == msp_pkg::A_STAT;
   endsequence
   a_bf_clear: assert property (s_data_rd ##2 s_stat_rd |=> !rdata_o[msp_pkg::B_BF])
      else $error("buffer full kept after data read");
   a_edge_count: assert property (sck_oe_o && $rose(port_irq_flag_o) |-> edges_q == 5'h10)
      else $error("master byte without 16 clock edges");
   a_irq_sticky: assert property (port_irq_flag_o
      && !(wr_i && addr_i == msp_pkg::A_IRQ && !wdata_i[0]) |=> port_irq_flag_o)
      else $error("completion flag lost");
   a_sleep_freeze: assert property (sck_oe_o && sleep_i && $past(sleep_i) |-> $stable(sck_o))
      else $error("clock moved in sleep");
   a_ss_release: assert property ($rose(ss_n_i) && !sck_oe_o && sdo_oe_o |-> ##[1:5] !sdo_oe_o)
      else $error("data out kept after deselect");
   a_oe_master: assert property (sck_oe_o |-> sdo_oe_o)
      else $error("master not driving data out");
   a_idle_quiet: assert property (sck_oe_o && port_irq_flag_o && $past(port_irq_flag_o)
      |-> $stable(sck_o))
      else $error("clock moved after byte end");
   a_slave_still: assert property (!sck_oe_o && !$past(sck_oe_o)
      && !$past(wr_i) && !$past(wr_i, 2) |-> $stable(sck_o))
      else $error("slave moved its clock output");
endmodule : msp_top_assertions
`default_nettype wire

// >>> verif/msp_far_end.sv
// far-end spi device: slave to a master dut, master to a slave dut
// slave role expects edge select set; master role runs an 80 ns clock
`timescale 1ns/1ps
`default_nettype none
module msp_far_end (
   input wire logic sck_i,
   input wire logic sck_oe_i,
   input wire logic sdo_i,
   output logic sck_o,
   output logic sdo_o,
   output logic ss_n_o
);
   logic [7:0] tx_q = 8'h00;
   logic [7:0] rx_q = 8'h00;
   logic m_q = 1'b0;
   initial begin
      sck_o = 1'b0;
      ss_n_o = 1'b1;
   end
   assign sdo_o = sck_oe_i ? tx_q[7] : m_q;
   always @(negedge sck_i) if (sck_oe_i) rx_q <= {rx_q[6:0], sdo_i};
   // change on trailing edge, stale bits become a pattern
   always @(posedge sck_i) if (sck_oe_i) tx_q <= {tx_q[6:0], ~tx_q[0]};
   task automatic load(input logic [7:0] b);
      tx_q = b;
   endtask : load
   task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      ss_n_o = 1'b0;
      #103;
      for (int i = 7; i > 7 - n; i--) begin
         m_q = tx[i];
         #40;
         sck_o = 1'b1;
         #35;
         rx = {rx[6:0], sdo_i};
         #5;
         sck_o = 1'b0;
      end
   endtask : xfer
   task automatic desel();
      ss_n_o = 1'b1;
      m_q = ~m_q;
      #200;
   endtask : desel
endmodule : msp_far_end
`default_nettype wire

// >>> verif/msp_top_bench.sv
// bench for msp_top with a far-end spi model
// reads are scored from a queue of expected values
`timescale 1ns/1ps
`default_nettype none
module msp_top_bench;
   logic mclk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [2:0] addr_i = 3'h0;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic sleep_i = 1'b0;
   logic tmr2_tick_i = 1'b0;
   logic [7:0] rdata_o;
   logic sck_o, sck_oe_o, sdo_o, sdo_oe_o, port_irq_flag_o, p_sck, p_sdo, ss_n;
   logic rd_q = 1'b0;
   logic sck_q = 1'b0;
   logic [9:0] cnt = 10'h000;
   logic [9:0] gap = 10'h000;
   logic [2:0] tc = 3'h0;
   logic [7:0] rq[$];
   logic [3:0] md[5] = '{msp_pkg::M_DIV4, msp_pkg::M_DIV16, msp_pkg::M_DIV64,
      msp_pkg::M_TMR2, msp_pkg::M_RELOAD};
   int n_fail = 0;
   int n_checks = 0;
   always #5 mclk_i = ~mclk_i;
   msp_top dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sleep_i(sleep_i), .tmr2_tick_i(tmr2_tick_i),
      .sck_i(sck_oe_o ? sck_o : p_sck), .sdi_i(p_sdo), .ss_n_i(ss_n), .sck_o(sck_o),
      .sck_oe_o(sck_oe_o), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .port_irq_flag_o(port_irq_flag_o));
   msp_far_end p (.sck_i(sck_o), .sck_oe_i(sck_oe_o), .sdo_i(sdo_o), .sck_o(p_sck),
      .sdo_o(p_sdo), .ss_n_o(ss_n));
   task automatic chk(input string nm, input logic [9:0] s, input logic [9:0] e);
      n_checks++;
      if (s !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : test_done
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge mclk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      rq.push_back(e);
      @(posedge mclk_i);
      rd_i <= 1'b0;
   endtask : rd
   task automatic wirq();
      for (int i = 0; i < 3000 && port_irq_flag_o !== 1'b1; i++) @(posedge mclk_i);
      chk("irq", port_irq_flag_o, 1'b1);
   endtask : wirq
   // read data, timer ticks every 6 cycles, clock half period
   always @(posedge mclk_i) begin
      if (rd_q) chk("rdata", rdata_o, rq.pop_front());
      rd_q <= rd_i;
      tc <= (tc == 3'h5) ? 3'h0 : tc + 3'h1;
      tmr2_tick_i <= (tc == 3'h5);
      sck_q <= sck_o;
      cnt <= (sck_o !== sck_q) ? 10'h001 : cnt + 10'h001;
      if (sck_o !== sck_q) gap <= cnt;
   end
   initial begin
      #300000;
      n_fail++;
      test_done();
   end
   initial begin
      logic [7:0] tx, pb, rx;
      logic [9:0] h;
      int r;
      r = $urandom(32'h7dd4ec3a);
      repeat (6) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
      for (int k = 0; k < 5; k++) begin
         r = $urandom_range(3);
         h = (k == 4) ? 10'(2 * (r + 1)) : (k == 3) ? 10'h006 : 10'h002 << (2 * k);
         wr(msp_pkg::A_RELOAD, 8'(r));
         wr(msp_pkg::A_STAT, 8'h40);
         wr(msp_pkg::A_CTL1, {4'h1, md[k]});
         wr(msp_pkg::A_CTL1, {4'h3, md[k]});
         repeat (3) @(posedge mclk_i);
         chk("sck_idle", sck_o, 1'b1);
         chk("sck_oe", sck_oe_o, 1'b1);
         pb = $urandom;
         tx = $urandom;
         p.load(pb);
         wr(msp_pkg::A_DATA, tx);
         wr(msp_pkg::A_DATA, ~tx);
         if (k == 2) begin
            sleep_i <= 1'b1;
            repeat (40) @(posedge mclk_i);
            sleep_i <= 1'b0;
         end
         wirq();
         chk("half", gap, h);
         chk("far_rx", p.rx_q, tx);
         rd(msp_pkg::A_CTL1, {4'hb, md[k]});
         rd(msp_pkg::A_DATA, pb);
         rd(msp_pkg::A_STAT, 8'h40);
         wr(msp_pkg::A_IRQ, 8'h00);
         wr(msp_pkg::A_CTL1, {4'h3, md[k]});
      end
      // plain slave, then slave with select control; phase clear
      wr(msp_pkg::A_CTL1, {4'h0, msp_pkg::M_SLV});
      wr(msp_pkg::A_STAT, 8'h00);
      wr(msp_pkg::A_CTL1, {4'h2, msp_pkg::M_SLV});
      repeat (3) @(posedge mclk_i);
      chk("oe_slave", {sck_oe_o, sdo_oe_o}, 2'b01);
      wr(msp_pkg::A_CTL1, {4'h0, msp_pkg::M_SLV_SS});
      wr(msp_pkg::A_STAT, 8'h40);
      wr(msp_pkg::A_CTL3, 8'h10);
      wr(msp_pkg::A_CTL1, {4'h2, msp_pkg::M_SLV_SS});
      tx = $urandom;
      pb = $urandom;
      wr(msp_pkg::A_DATA, tx);
      sleep_i <= 1'b1;
      p.xfer(pb, 8, rx);
      chk("chain0", rx, tx);
      p.xfer(8'h5a, 8, rx);
      p.desel();
      chk("chain1", rx, pb);
      wirq();
      sleep_i <= 1'b0;
      rd(msp_pkg::A_DATA, 8'h5a);
      wr(msp_pkg::A_IRQ, 8'h00);
      p.xfer(8'hc3, 3, rx);
      chk("sdo_on", sdo_oe_o, 1'b1);
      p.desel();
      chk("sdo_off", sdo_oe_o, 1'b0);
      p.xfer(8'h96, 8, rx);
      p.desel();
      rd(msp_pkg::A_DATA, 8'h96);
      repeat (3) @(posedge mclk_i);
      test_done();
   end
endmodule : msp_top_bench
bind msp_top msp_top_assertions u_chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sleep_i(sleep_i),
   .ss_n_i(ss_n_i), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .sdo_oe_o(sdo_oe_o),
   .port_irq_flag_o(port_irq_flag_o));
`default_nettype wire
